// >>> dev_calc.sv
// Combinational symbol and idle deviation calculator
`timescale 1ns/1ps
module dev_calc
	import dev_map_pkg::*;
(
	dev_cfg_if.calc cfg
);
	function automatic logic [15:0] thirdOf(input logic [15:0] v);
		return 16'(v / 16'd3);
	endfunction

	logic [15:0]        outer;
	logic [15:0]        idleMag;
	logic [15:0]        mag;
	logic               neg;
	logic               twoLvl;
	logic signed [15:0] devV;

	always_comb begin
		outer   = (cfg.mode == MODE_2L3200) ? FIXED_DEV : cfg.nomDev;
		idleMag = (cfg.mode == MODE_2L1600) ? cfg.nomDev : FIXED_DEV;
		twoLvl  = (cfg.mode == MODE_2L1600) || (cfg.mode == MODE_2L3200);
		if (twoLvl) begin
			mag = outer;
			neg = !cfg.symData[0];
		end else begin
			mag = cfg.symData[0] ? thirdOf(outer) : outer;
			neg = !cfg.symData[1];
		end
		if (cfg.invert) begin
			neg = !neg;
		end
		devV = '0;
		if (!cfg.keyed) begin
			devV = '0;
		end else if (cfg.valid) begin
			devV = neg ? -$signed(mag) : $signed(mag);
		end else if (!cfg.align) begin
			case (cfg.idleSel)
				IDLE_SPACE: devV = -$signed(idleMag);
				IDLE_MARK:  devV = $signed(idleMag);
				default:    devV = '0;
			endcase
		end
	end

	assign cfg.dev = devV;
endmodule

// >>> dev_cfg_if.sv
// Configuration and symbol carrier between mapper and deviation calculator
`timescale 1ns/1ps
interface dev_cfg_if;
	import dev_map_pkg::*;
	mode_t              mode;
	idle_t              idleSel;
	logic               invert;
	logic               align;
	logic               keyed;
	logic               valid;
	logic [1:0]         symData;
	logic [15:0]        nomDev;
	logic signed [15:0] dev;

	modport src  (output mode, idleSel, invert, align, keyed, valid, symData, nomDev,
		input dev);
	modport calc (input mode, idleSel, invert, align, keyed, valid, symData, nomDev,
		output dev);
endinterface

// >>> dev_map_pkg.sv
// Constants and types shared by the deviation symbol mapper
package dev_map_pkg;
	// ==========================================
	// Timing
	localparam int CLK_HZ  = 50_000_000;
	localparam int BAUD_LO = 1600;
	localparam int BAUD_HI = 3200;
	localparam int CYC_LO  = CLK_HZ / BAUD_LO;
	localparam int CYC_HI  = CLK_HZ / BAUD_HI;

	// ==========================================
	// Deviation figures in hertz
	localparam logic [15:0] NOM_MAX   = 16'h1b58;
	localparam logic [15:0] NOM_RST   = 16'h12c0;
	localparam logic [15:0] FIXED_DEV = 16'h12c0;
	localparam logic [17:0] SHIFT_HZ  = 18'h186a0;

	// ==========================================
	// Register offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_NOM  = 12'h004;
	localparam logic [11:0] OFF_CHAN = 12'h008;
	localparam logic [11:0] OFF_IDLE = 12'h00c;
	localparam logic [11:0] OFF_DEV  = 12'h010;

	// ==========================================
	// Fields and reset values
	localparam int CTRL_INV  = 0;
	localparam int CTRL_TXRX = 1;
	localparam int CTRL_DIR  = 2;
	localparam int CTRL_MODE = 4;
	localparam int STEP_UP   = 0;
	localparam int STEP_DN   = 1;
	localparam logic [3:0] CHAN_MIN = 4'h1;
	localparam logic [3:0] CHAN_MAX = 4'h8;
	localparam logic [3:0] CHAN_RST = 4'h1;

	typedef enum logic [1:0] {MODE_2L1600, MODE_2L3200, MODE_4L3200, MODE_4L6400} mode_t;
	typedef enum logic [1:0] {IDLE_NULL, IDLE_SPACE, IDLE_MARK} idle_t;
endpackage

// >>> dev_mod_sink.sv
// Behavioural modulator input that sums symbol deviation and channel shift
`timescale 1ns/1ps
module dev_mod_sink (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Mapper outputs
	input  wire logic signed [15:0] devIn,
	input  wire logic signed [17:0] shiftIn,
	// Carrier offset seen by the synthesizer
	output logic signed [18:0]      carrierHz
);
	always_ff @(posedge clk) begin
		if (rst) begin
			carrierHz <= '0;
		end else begin
			carrierHz <= 19'(shiftIn) + 19'(devIn);
		end
	end
endmodule

// >>> deviation_symbol_mapper.sv
// Top of the paging symbol to carrier deviation mapper with APB registers
`timescale 1ns/1ps
module deviation_symbol_mapper
	import dev_map_pkg::*;
#(
	parameter int CYC_1600 = CYC_LO,
	parameter int CYC_3200 = CYC_HI
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Symbol source
	input  wire logic [1:0]         symData,
	input  wire logic               symValid,
	output logic                    symTake,
	// Station state
	input  wire logic               keyedPin,
	input  wire logic               alignPin,
	input  wire logic [3:0]         txChannel,
	// Modulator side
	output logic signed [15:0]      devOut,
	output logic signed [17:0]      freqShift
);
	initial begin
		if (CYC_1600 < 2 || CYC_1600 > 65535 || CYC_3200 < 2 || CYC_3200 > 65535)
			$error("symbol period out of range");
	end

	// ==========================================
	// Pin synchronisers
	logic keyedMeta_q;
	logic keyed_q;
	logic alignMeta_q;
	logic align_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			keyedMeta_q <= 1'b0;
			keyed_q     <= 1'b0;
			alignMeta_q <= 1'b0;
			align_q     <= 1'b0;
		end else begin
			keyedMeta_q <= keyedPin;
			keyed_q     <= keyedMeta_q;
			alignMeta_q <= alignPin;
			align_q     <= alignMeta_q;
		end
	end

	// ==========================================
	// APB handshake
	logic        access;
	logic        wrEn;
	logic        mapped;
	logic        nomBad;
	logic [31:0] rdVal;

	logic        invert_q;
	logic        txRx_q;
	logic        shiftDn_q;
	mode_t       mode_q;
	logic [15:0] nomDev_q;
	logic [3:0]  rxChan_q;
	idle_t       idle_q;

	assign access = psel && penable && !pready;
	assign wrEn   = psel && penable && pready && pwrite && !pslverr;
	assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_NOM) || (paddr == OFF_CHAN)
		|| (paddr == OFF_IDLE) || (paddr == OFF_DEV);
	assign nomBad = pwrite && (paddr == OFF_NOM) && (pwdata[15:0] > NOM_MAX);

	always_comb begin
		rdVal = '0;
		case (paddr)
			OFF_CTRL: rdVal = {26'h0, mode_q, 1'b0, shiftDn_q, txRx_q, invert_q};
			OFF_NOM:  rdVal = {16'h0, nomDev_q};
			OFF_CHAN: rdVal = {28'h0, rxChan_q};
			OFF_IDLE: rdVal = {30'h0, idle_q};
			OFF_DEV:  rdVal = {{16{devOut[15]}}, devOut};
			default:  rdVal = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= access;
			pslverr <= access && (!mapped || nomBad);
			prdata  <= (access && !pwrite) ? rdVal : '0;
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			invert_q  <= 1'b0;
			txRx_q    <= 1'b0;
			shiftDn_q <= 1'b0;
			mode_q    <= MODE_2L1600;
		end else if (wrEn && paddr == OFF_CTRL) begin
			invert_q  <= pwdata[CTRL_INV];
			txRx_q    <= pwdata[CTRL_TXRX];
			shiftDn_q <= pwdata[CTRL_DIR];
			mode_q    <= mode_t'(pwdata[CTRL_MODE +: 2]);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			nomDev_q <= NOM_RST;
		end else if (wrEn && paddr == OFF_NOM) begin
			nomDev_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rxChan_q <= CHAN_RST;
		end else if (wrEn && paddr == OFF_CHAN) begin
			if (pwdata[STEP_UP]) begin
				rxChan_q <= (rxChan_q == CHAN_MAX) ? CHAN_MIN : rxChan_q + 4'h1;
			end else if (pwdata[STEP_DN]) begin
				rxChan_q <= (rxChan_q == CHAN_MIN) ? CHAN_MAX : rxChan_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			idle_q <= IDLE_NULL;
		end else if (wrEn && paddr == OFF_IDLE && pwdata[STEP_UP]) begin
			case (idle_q)
				IDLE_SPACE: idle_q <= IDLE_MARK;
				IDLE_MARK:  idle_q <= IDLE_NULL;
				default:    idle_q <= IDLE_SPACE;
			endcase
		end
	end

	// ==========================================
	// Symbol timing and deviation
	logic        tick;
	logic [15:0] period;

	assign period = (mode_q == MODE_2L1600) ? 16'(CYC_1600) : 16'(CYC_3200);

	sym_tick #(.W(16)) u_tick (
		.clk    (clk),
		.rst    (rst),
		.period (period),
		.tick   (tick)
	);

	dev_cfg_if cfg ();

	assign cfg.mode    = mode_q;
	assign cfg.idleSel = idle_q;
	assign cfg.invert  = invert_q;
	assign cfg.align   = align_q;
	assign cfg.keyed   = keyed_q;
	assign cfg.valid   = symValid;
	assign cfg.symData = symData;
	assign cfg.nomDev  = nomDev_q;

	dev_calc u_calc (
		.cfg (cfg.calc)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			devOut  <= '0;
			symTake <= 1'b0;
		end else begin
			symTake <= tick && keyed_q && symValid;
			if (tick) begin
				devOut <= cfg.dev;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			freqShift <= '0;
		end else if (tick) begin
			if (txRx_q && !keyed_q && txChannel == rxChan_q) begin
				freqShift <= shiftDn_q ? -$signed(SHIFT_HZ) : $signed(SHIFT_HZ);
			end else begin
				freqShift <= '0;
			end
		end
	end

	// ==========================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_nomRange;
		nomDev_q <= NOM_MAX;
	endproperty
	a_nomRange: assert property (p_nomRange) else $error("nominal deviation over range");

	property p_fixed;
		tick && keyed_q && symValid && mode_q == MODE_2L3200
			|=> devOut == 16'sd4800 || devOut == -16'sd4800;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed deviation not used");

	property p_map;
		tick && keyed_q && symValid && !invert_q && mode_q == MODE_2L1600
			|=> devOut == ($past(symData[0]) ? $signed($past(nomDev_q))
			: -$signed($past(nomDev_q)));
	endproperty
	a_map: assert property (p_map) else $error("two-level mapping wrong");

	property p_inv;
		tick && keyed_q && symValid && invert_q && symData == 2'b10
			&& mode_q == MODE_4L6400 |=> devOut == -$signed($past(nomDev_q));
	endproperty
	a_inv: assert property (p_inv) else $error("inversion wrong");

	property p_inner;
		tick && keyed_q && symValid && !invert_q && symData == 2'b11
			&& mode_q == MODE_4L3200 |=> devOut == $signed($past(nomDev_q) / 16'd3);
	endproperty
	a_inner: assert property (p_inner) else $error("inner level wrong");

	property p_shift;
		tick && (txChannel != rxChan_q || keyed_q || !txRx_q) |=> freqShift == 18'sd0;
	endproperty
	a_shift: assert property (p_shift) else $error("unexpected frequency shift");

	property p_idleNull;
		tick && keyed_q && !symValid && (align_q || idle_q == IDLE_NULL) |=> devOut == 16'sd0;
	endproperty
	a_idleNull: assert property (p_idleNull) else $error("idle not null");

	property p_idleLo;
		tick && keyed_q && !symValid && !align_q && idle_q == IDLE_MARK
			&& mode_q == MODE_2L1600 |=> devOut == $signed($past(nomDev_q));
	endproperty
	a_idleLo: assert property (p_idleLo) else $error("low rate idle wrong");

	property p_idleHi;
		tick && keyed_q && !symValid && !align_q && idle_q == IDLE_SPACE
			&& mode_q != MODE_2L1600 |=> devOut == -16'sd4800;
	endproperty
	a_idleHi: assert property (p_idleHi) else $error("high rate idle wrong");

	property p_hold;
		!tick |=> $stable(devOut) && $stable(freqShift);
	endproperty
	a_hold: assert property (p_hold) else $error("output changed off boundary");

	property p_chan;
		rxChan_q >= CHAN_MIN && rxChan_q <= CHAN_MAX;
	endproperty
	a_chan: assert property (p_chan) else $error("channel out of range");

	property p_idleStep;
		wrEn && paddr == OFF_IDLE && pwdata[0] && idle_q == IDLE_NULL |=> idle_q == IDLE_SPACE;
	endproperty
	a_idleStep: assert property (p_idleStep) else $error("idle step wrong");

	c_shift: cover property (tick && txRx_q && !keyed_q && txChannel == rxChan_q);
	c_inner: cover property (tick && keyed_q && symValid && mode_q == MODE_4L6400);
	c_idle:  cover property (tick && keyed_q && !symValid && idle_q == IDLE_MARK);
endmodule

// >>> deviation_symbol_mapper_tb.sv
// Self-checking bench for the deviation symbol mapper
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin numErrors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module deviation_symbol_mapper_tb
	import dev_map_pkg::*;
;
	localparam int P0 = 20;
	localparam int P1 = 10;
	logic               clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic               keyedPin = 0, alignPin = 0, symValid = 0;
	logic               pready, pslverr, symTake, rdErr;
	logic [11:0]        paddr = '0;
	logic [31:0]        pwdata = '0, prdata, rdVal;
	logic [31:0]        seed = 32'h5b;
	logic [1:0]         symData = '0, s;
	logic [3:0]         txChannel = 4'h1;
	logic signed [15:0] devOut;
	logic signed [17:0] freqShift, sh;
	logic signed [18:0] carrierHz;
	int                 numErrors = 0, checksDone = 0, nom, e;

	always #10 clk = ~clk;

	deviation_symbol_mapper #(.CYC_1600(P0), .CYC_3200(P1)) u_deviation_symbol_mapper (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .symData(symData), .symValid(symValid), .symTake(symTake),
		.keyedPin(keyedPin), .alignPin(alignPin), .txChannel(txChannel),
		.devOut(devOut), .freqShift(freqShift));
	dev_mod_sink u_dev_mod_sink (.clk(clk), .rst(rst), .devIn(devOut),
		.shiftIn(freqShift), .carrierHz(carrierHz));

	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic signed [15:0] expDev(int m, logic [1:0] sy, logic inv, int n);
		int o;
		int v;
		o = (m == 1) ? int'(FIXED_DEV) : n;
		if (m < 2) v = sy[0] ? o : -o;
		else if (sy == 2'b10) v = o;
		else if (sy == 2'b11) v = o / 3;
		else if (sy == 2'b01) v = -(o / 3);
		else v = -o;
		return 16'(inv ? -v : v);
	endfunction

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Request held until pready is sampled high; data taken at that edge
		do @(posedge clk); while (pready !== 1'b1);
		rdVal = prdata;
		rdErr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask

	task automatic printVerdict();
		$display("errors %0d checks %0d", numErrors, checksDone);
		if (numErrors == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		numErrors++;
		printVerdict();
	end

	// ==========================================
	// Main sequence
	initial begin
		cyc(5);
		rst <= 0;
		keyedPin <= 1;
		cyc(1);
		apb(0, OFF_CTRL, 0);
		`CHK(rdVal, 32'h0)
		apb(0, OFF_NOM, 0);
		`CHK(rdVal, 32'(NOM_RST))
		apb(0, 12'h020, 0);
		`CHK(rdErr, 1'b1)
		apb(1, OFF_NOM, 32'h1b59);
		`CHK(rdErr, 1'b1)
		apb(1, OFF_NOM, 32'(NOM_MAX));
		`CHK(rdErr, 1'b0)
		apb(0, OFF_NOM, 0);
		`CHK(rdVal, 32'(NOM_MAX))
		apb(1, OFF_CHAN, 32'h2);
		apb(0, OFF_CHAN, 0);
		`CHK(rdVal, 32'h8)
		apb(1, OFF_CHAN, 32'h1);
		apb(0, OFF_CHAN, 0);
		`CHK(rdVal, 32'h1)
		// Every symbol value first, then random ones, each mode plain and inverted
		for (int m = 0; m < 4; m++) begin
			for (int inv = 0; inv < 2; inv++) begin
				nom = rnd() % 7001;
				apb(1, OFF_NOM, 32'(nom));
				apb(1, OFF_CTRL, 32'((m << CTRL_MODE) | inv));
				for (int r = 0; r < 8; r++) begin
					s = (r < 4) ? 2'(r) : 2'(rnd());
					symData <= s;
					symValid <= 1;
					// Skip a take launched before the new symbol stood
					@(posedge clk);
					do @(posedge clk); while (symTake !== 1'b1);
					e = expDev(m, s, 1'(inv), nom);
					`CHK(devOut, 16'(e))
				end
			end
		end
		// Keyed idle: space, mark, null in every mode
		symValid <= 0;
		for (int m = 0; m < 4; m++) begin
			apb(1, OFF_CTRL, 32'(m << CTRL_MODE));
			for (int k = 1; k < 4; k++) begin
				apb(1, OFF_IDLE, 32'h1);
				apb(0, OFF_IDLE, 0);
				`CHK(rdVal, 32'(k % 3))
				cyc(45);
				e = (k == 3) ? 0 : ((m == 0) ? nom : int'(FIXED_DEV));
				e = (k == 1) ? -e : e;
				`CHK(devOut, 16'(e))
				apb(0, OFF_DEV, 0);
				`CHK(rdVal, 32'(e))
			end
		end
		alignPin <= 1;
		apb(1, OFF_IDLE, 32'h1);
		cyc(45);
		`CHK(devOut, 16'h0)
		alignPin <= 0;
		// Unkeyed channel shift both ways, then another channel
		keyedPin <= 0;
		for (int d = 0; d < 2; d++) begin
			apb(1, OFF_CTRL, 32'((d << CTRL_DIR) | (1 << CTRL_TXRX)));
			cyc(45);
			sh = d ? -$signed(SHIFT_HZ) : $signed(SHIFT_HZ);
			`CHK(freqShift, sh)
			`CHK(carrierHz, 19'(sh))
		end
		txChannel <= 4'h3;
		cyc(45);
		`CHK(freqShift, 18'h0)
		printVerdict();
	end
endmodule

// >>> sym_tick.sv
// Symbol-rate enable pulse divider
`timescale 1ns/1ps
module sym_tick #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Period in clock cycles
	input  wire logic [W-1:0] period,
	// One-cycle enable
	output logic              tick
);
	initial begin
		if (W < 2) $error("sym_tick width too small");
	end

	logic [W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst || cnt_q >= period - W'(1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= (cnt_q >= period - W'(1));
		end
	end
endmodule
